// ### rtl/sip_frame_timer.sv
// Purpose: frame period counter with preflash window at frame start
// Assumes: shutter time given in clocks by the exposure logic
// Notes:   settings are sampled once per frame, at its first cycle
`timescale 1ns/1ps
`default_nettype none
module sip_frame_timer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // control
  input  wire logic        run,
  input  wire logic        restart,
  // settings
  input  wire logic [15:0] shutter_time,
  input  wire logic [7:0]  frame_gap,
  input  wire logic [7:0]  illum_preflash_bits,
  // status
  output logic             frame_start,
  output logic             preflash_active
);
  logic [17:0] count_reg;
  logic [17:0] period_reg;
  logic [17:0] preflash_reg;
  logic [17:0] period_next;
  logic [17:0] preflash_next;

  // gap widens the period, lowering the frame rate
  assign period_next = 18'(shutter_time) + sip_pkg::FRAME_BASE
                       + 18'(frame_gap) * sip_pkg::STEP_CLOCKS;               // [R2] [R3]
  assign preflash_next = 18'(illum_preflash_bits) * sip_pkg::STEP_CLOCKS
                         + sip_pkg::PREFLASH_BASE;                            // [R1]

  always_ff @(posedge clock) begin
    if (reset || restart || !run) begin
      count_reg    <= 18'h00000;
      period_reg   <= 18'h00000;
      preflash_reg <= 18'h00000;
    end else begin
      if (count_reg == 18'h00000) begin
        period_reg   <= period_next;
        preflash_reg <= preflash_next;
      end
      if (count_reg != 18'h00000 && count_reg == period_reg - 18'h00001) begin
        count_reg <= 18'h00000;                                               // [R3]
      end else begin
        count_reg <= count_reg + 18'h00001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || restart || !run) begin
      frame_start     <= 1'b0;
      preflash_active <= 1'b0;
    end else begin
      frame_start <= (count_reg == 18'h00000);
      // first cycle uses fresh setting, later cycles the latched one
      if (count_reg == 18'h00000) begin
        preflash_active <= (preflash_next > 18'h00000);                       // [R1]
      end else begin
        preflash_active <= (count_reg < preflash_reg);                        // [R1]
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/sip_illum_current.sv
// Purpose: picks the drive current of the light source
// Assumes: brightness flag from the image path, same clock
// Notes:   purely combinational, the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module sip_illum_current (
  // configuration
  input  wire logic [1:0] fixed_current_code,
  input  wire logic [1:0] adaptive_high_current,
  input  wire logic       adaptive_low_current,
  input  wire logic       adaptive_switch_off,
  // surface
  input  wire logic       surface_bright,
  // result
  output logic      [5:0] current_ma
);
  logic [5:0] fixed_ma;
  logic [5:0] high_ma;
  logic [5:0] low_ma;

  always_comb begin
    case (fixed_current_code)                                     // [R10]
      2'h0:    fixed_ma = sip_pkg::MA_20;
      2'h1:    fixed_ma = sip_pkg::MA_15;
      2'h2:    fixed_ma = sip_pkg::MA_36;
      default: fixed_ma = sip_pkg::MA_30;
    endcase
    case (adaptive_high_current)                                  // [R15]
      2'h0:    high_ma = sip_pkg::MA_15;
      2'h1:    high_ma = sip_pkg::MA_20;
      2'h2:    high_ma = sip_pkg::MA_30;
      default: high_ma = sip_pkg::MA_36;
    endcase
    low_ma = adaptive_low_current ? sip_pkg::MA_20 : sip_pkg::MA_15; // [R16]
    if (adaptive_switch_off) begin
      current_ma = fixed_ma;                                      // [R11]
    end else if (low_ma > high_ma) begin
      current_ma = low_ma;                                        // [R18]
    end else begin
      current_ma = surface_bright ? low_ma : high_ma;             // [R14]
    end
  end
endmodule
`default_nettype wire

// ### rtl/sip_illum_power_regs.sv
// Purpose: illumination, frame timing, reset, power-down and mode registers
// Assumes: register port strobes come from the serial port on this clock
// Notes:   read data returns one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module sip_illum_power_regs (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // register port
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // image path status
  input  wire logic [7:0]  revision_id,
  input  wire logic [15:0] shutter_time,
  input  wire logic        surface_bright,
  input  wire logic [1:0]  rest_state_auto,
  input  wire logic        motion_event,
  input  wire logic        motion_clear,
  // illumination
  output logic             illum_on,
  output logic      [5:0]  illum_current_ma,
  // motion pin
  output logic             motion_out,
  // power and mode
  output logic             full_reset_pulse,
  output logic             partial_reset_pulse,
  output logic             powered_down,
  output logic             forced_rest,
  output logic      [1:0]  operating_state_field,
  output logic             frame_start
);
  // ************************************************************
  // decode
  // ************************************************************
  sip_pkg::sip_pwr_t pwr_reg;
  logic [7:0] preflash_reg;
  logic [7:0] gap_reg;
  logic [7:0] illum_control_reg;
  logic [7:0] motion_cfg_reg;
  logic [7:0] adaptive_reg;
  logic [1:0] forced_state_reg;
  logic       forced_rest_reg;
  logic       motion_pending_reg;
  logic       motion_edge_reg;
  logic       full_hit;
  logic       part_hit;
  logic       down_hit;
  logic       cfg_write;
  logic       restore;
  logic       preflash_active;
  logic [5:0] current_next;
  logic [1:0] state_now;
  logic       motion_level;

  assign full_hit = reg_write && reg_addr == sip_pkg::ADDR_RESET &&
                    (reg_wdata == sip_pkg::CMD_FULL_A ||
                     reg_wdata == sip_pkg::CMD_FULL_B);                // [R4] [R6]
  assign part_hit = reg_write && reg_addr == sip_pkg::ADDR_RESET &&
                    pwr_reg == sip_pkg::PWR_RUN &&
                    (reg_wdata == sip_pkg::CMD_PART_A ||
                     reg_wdata == sip_pkg::CMD_PART_B);                // [R4]
  assign down_hit = reg_write && reg_addr == sip_pkg::ADDR_DOWN &&
                    reg_wdata == sip_pkg::CMD_DOWN;                    // [R5]
  // a sleeping device only listens for the wake command
  assign cfg_write = reg_write && pwr_reg == sip_pkg::PWR_RUN;
  assign restore   = reset || full_hit;
  assign state_now = forced_rest_reg ? forced_state_reg : rest_state_auto;

  // ************************************************************
  // power state
  // ************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      pwr_reg <= sip_pkg::PWR_RUN;
    end else begin
      case (pwr_reg)
        sip_pkg::PWR_RUN: begin
          if (down_hit) begin
            pwr_reg <= sip_pkg::PWR_DOWN;                              // [R5]
          end
        end
        sip_pkg::PWR_DOWN: begin
          if (full_hit) begin
            pwr_reg <= sip_pkg::PWR_RUN;                               // [R6]
          end
        end
        default: pwr_reg <= sip_pkg::PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      full_reset_pulse    <= 1'b0;
      partial_reset_pulse <= 1'b0;
      powered_down        <= 1'b0;
    end else begin
      full_reset_pulse    <= full_hit;                                 // [R4]
      partial_reset_pulse <= part_hit;                                 // [R4]
      powered_down        <= (pwr_reg == sip_pkg::PWR_RUN) ? down_hit : !full_hit;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (restore) begin
      preflash_reg <= sip_pkg::RST_PREFLASH;
      gap_reg      <= sip_pkg::RST_GAP;
    end else if (cfg_write && reg_addr == sip_pkg::ADDR_PREFLASH) begin
      preflash_reg <= reg_wdata;                                       // [R1]
    end else if (cfg_write && reg_addr == sip_pkg::ADDR_GAP) begin
      gap_reg <= reg_wdata;                                            // [R2]
    end
  end

  always_ff @(posedge clock) begin
    if (restore) begin
      illum_control_reg <= sip_pkg::RST_ILLUM;
      motion_cfg_reg    <= sip_pkg::RST_MOTION;                        // [R12] [R13]
      adaptive_reg      <= sip_pkg::RST_ADAPT;                         // [R17]
    end else if (cfg_write) begin
      // reserved bits never store, so they read zero
      if (reg_addr == sip_pkg::ADDR_ILLUM) begin
        illum_control_reg <= reg_wdata & sip_pkg::MASK_ILLUM;          // [R22]
      end
      if (reg_addr == sip_pkg::ADDR_MOTION) begin
        motion_cfg_reg <= reg_wdata & sip_pkg::MASK_MOTION;            // [R22]
      end
      if (reg_addr == sip_pkg::ADDR_ADAPT) begin
        adaptive_reg <= reg_wdata & sip_pkg::MASK_ADAPT;               // [R22]
      end
    end
  end

  // ************************************************************
  // forced rest mode
  // ************************************************************
  always_ff @(posedge clock) begin
    if (restore || part_hit) begin
      forced_rest_reg  <= 1'b0;
      forced_state_reg <= 2'h0;
    end else if (cfg_write && reg_addr == sip_pkg::ADDR_OPSTATE) begin
      case (reg_wdata)
        sip_pkg::MODE_REST1,
        sip_pkg::MODE_REST2,
        sip_pkg::MODE_REST3: begin
          forced_rest_reg  <= 1'b1;                                    // [R20]
          forced_state_reg <= reg_wdata[sip_pkg::STATE_LSB +: 2];
        end
        sip_pkg::MODE_NORMAL: begin
          forced_rest_reg  <= 1'b0;                                    // [R21]
          forced_state_reg <= 2'h0;
        end
        // other codes leave the mode alone
        default: forced_rest_reg <= forced_rest_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      forced_rest           <= 1'b0;
      operating_state_field <= 2'h0;
    end else begin
      forced_rest           <= forced_rest_reg;
      operating_state_field <= state_now;                              // [R19]
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        case (reg_addr)
          sip_pkg::ADDR_PREFLASH: reg_rdata <= preflash_reg;
          sip_pkg::ADDR_GAP:      reg_rdata <= gap_reg;
          sip_pkg::ADDR_INVREV:   reg_rdata <= ~revision_id;           // [R7]
          sip_pkg::ADDR_ILLUM:    reg_rdata <= illum_control_reg;
          sip_pkg::ADDR_MOTION:   reg_rdata <= motion_cfg_reg;
          sip_pkg::ADDR_ADAPT:    reg_rdata <= adaptive_reg;
          sip_pkg::ADDR_OPSTATE:  reg_rdata <= {state_now, 6'h00};     // [R19] [R22]
          default:                reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ************************************************************
  // frame timing and illumination
  // ************************************************************
  sip_frame_timer u_timer (
    .clock               (clock),
    .reset               (reset),
    .run                 (pwr_reg == sip_pkg::PWR_RUN),
    .restart             (part_hit || full_hit),
    .shutter_time        (shutter_time),
    .frame_gap           (gap_reg),
    .illum_preflash_bits (preflash_reg),
    .frame_start         (frame_start),
    .preflash_active     (preflash_active)
  );

  sip_illum_current u_current (
    .fixed_current_code    (illum_control_reg[sip_pkg::FIX_LSB +: 2]),
    .adaptive_high_current (adaptive_reg[sip_pkg::HIGH_LSB +: 2]),
    .adaptive_low_current  (adaptive_reg[sip_pkg::BIT_LOW]),
    .adaptive_switch_off   (adaptive_reg[sip_pkg::BIT_ADAPT_OFF]),
    .surface_bright        (surface_bright),
    .current_ma            (current_next)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      illum_on         <= 1'b0;
      illum_current_ma <= 6'h00;
    end else begin
      illum_current_ma <= current_next;                                // [R10] [R11]
      if (pwr_reg != sip_pkg::PWR_RUN) begin
        illum_on <= 1'b0;
      end else if (illum_control_reg[sip_pkg::BIT_FORCE_OFF]) begin
        illum_on <= 1'b0;                                              // [R8]
      end else if (illum_control_reg[sip_pkg::BIT_FORCE_ON]) begin
        illum_on <= 1'b1;                                              // [R9]
      end else begin
        illum_on <= preflash_active;
      end
    end
  end

  // ************************************************************
  // motion pin
  // ************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      motion_pending_reg <= 1'b0;
      motion_edge_reg    <= 1'b0;
    end else begin
      // a new event beats a clear in the same cycle
      motion_pending_reg <= motion_event || (motion_pending_reg && !motion_clear);
      motion_edge_reg    <= motion_event && !motion_pending_reg;
    end
  end

  assign motion_level = motion_cfg_reg[sip_pkg::BIT_EDGE] ? motion_edge_reg
                                                          : motion_pending_reg; // [R13]

  always_ff @(posedge clock) begin
    if (reset) begin
      motion_out <= 1'b1;
    end else begin
      motion_out <= motion_cfg_reg[sip_pkg::BIT_POLARITY] ? motion_level
                                                          : !motion_level;      // [R12]
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence wr_reset_cmd(logic [7:0] code);
    reg_write && reg_addr == sip_pkg::ADDR_RESET && reg_wdata == code;
  endsequence

  chk_full_reset_cmd: assert property ( // [R4]
    wr_reset_cmd(sip_pkg::CMD_FULL_B) |=> full_reset_pulse ##1 !full_reset_pulse
  ) else $error("full reset command gave no single pulse");

  chk_partial_reset_cmd: assert property ( // [R4]
    (wr_reset_cmd(sip_pkg::CMD_PART_A) and (pwr_reg == sip_pkg::PWR_RUN))
      |=> partial_reset_pulse && !full_reset_pulse
  ) else $error("partial reset command not decoded");

  chk_power_down_cmd: assert property ( // [R5]
    (down_hit && pwr_reg == sip_pkg::PWR_RUN) |=> powered_down ##1 !illum_on
  ) else $error("power-down command ignored");

  chk_wake_on_full: assert property ( // [R6]
    (powered_down and wr_reset_cmd(sip_pkg::CMD_FULL_A)) |=> !powered_down
  ) else $error("full reset did not wake the device");

  chk_inverted_revision: assert property ( // [R7]
    (reg_read && reg_addr == sip_pkg::ADDR_INVREV) |=> reg_rdata == ~$past(revision_id)
  ) else $error("inverted revision mismatch");

  chk_force_off_light: assert property ( // [R8]
    illum_control_reg[sip_pkg::BIT_FORCE_OFF] |=> !illum_on
  ) else $error("light on while forced off");

  chk_force_on_light: assert property ( // [R9]
    (illum_control_reg[3:2] == 2'b01 && pwr_reg == sip_pkg::PWR_RUN) |=> illum_on
  ) else $error("light off while forced on");

  chk_fixed_current: assert property ( // [R11]
    (adaptive_reg[sip_pkg::BIT_ADAPT_OFF] && illum_control_reg[1:0] == 2'h2)
      |=> illum_current_ma == sip_pkg::MA_36
  ) else $error("fixed current selection not applied");

  chk_adaptive_max: assert property ( // [R18]
    (adaptive_reg[3:0] == 4'h2) |=> illum_current_ma == sip_pkg::MA_20
  ) else $error("adaptive low above high not held at higher value");

  chk_forced_rest_two: assert property ( // [R20]
    (cfg_write && reg_addr == sip_pkg::ADDR_OPSTATE && reg_wdata == sip_pkg::MODE_REST2)
      |=> ##1 forced_rest && operating_state_field == 2'h2
  ) else $error("forced rest two not entered");

  chk_rest_release: assert property ( // [R21]
    (cfg_write && reg_addr == sip_pkg::ADDR_OPSTATE && reg_wdata == sip_pkg::MODE_NORMAL)
      |=> !forced_rest_reg
  ) else $error("forced rest not released");

  chk_reserved_zero: assert property ( // [R22]
    (reg_read && reg_addr == sip_pkg::ADDR_MOTION) |=> reg_rdata[5:0] == 6'h00
  ) else $error("reserved bits read nonzero");

  // fresh event in edge mode with the low-active default
  sequence motion_edge_start;
    motion_cfg_reg == sip_pkg::RST_MOTION && motion_event && !motion_pending_reg;
  endsequence

  chk_motion_edge_pulse: assert property ( // [R13]
    motion_edge_start ##1 (motion_cfg_reg == sip_pkg::RST_MOTION) |=> !motion_out
  ) else $error("edge mode gave no motion pulse");

  chk_motion_level_high: assert property ( // [R12]
    (motion_cfg_reg[sip_pkg::BIT_POLARITY] && !motion_cfg_reg[sip_pkg::BIT_EDGE]
      && motion_pending_reg) |=> motion_out
  ) else $error("level motion not shown active high");
endmodule
`default_nettype wire

// ### rtl/sip_pkg.sv
// Purpose: constants for the illumination, power and mode register group
// Assumes: registers reached through a byte-wide register port, one clock
// Notes:   counts below are in cycles of the block clock
// Behaviour
// R1 - preflash lasts preflash setting times 32 plus 30 clocks
// R2 - idle gap after each frame lasts gap setting times 32 clocks
// R3 - frame period is shutter time plus 3400 clocks plus idle gap
// R4 - reset command 0x5a/0x5b gives full reset, 0x96/0x97 partial reset
// R5 - power-down command 0xe7 puts the device into powered-down state
// R6 - controller wakes a powered-down device by writing 0x5a to reset command
// R7 - inverted revision reads back the bitwise inverse of the revision value
// R8 - illumination control bit 3 keeps the light source off
// R9 - illumination control bit 2 keeps the light source on
// R10 - fixed current code decodes 00=20, 01=15, 10=36, 11=30 mA
// R11 - fixed current code applies only while adaptive switching is off
// R12 - motion config bit 7 picks output polarity, low active by default
// R13 - motion config bit 6 picks level or edge signalling, edge by default
// R14 - adaptive mode uses lower current on brighter surfaces, between low and high
// R15 - adaptive high code in bits 3:2 decodes 15, 20, 30, 36 mA
// R16 - adaptive low bit decodes 15 mA when clear, 20 mA when set
// R17 - adaptive config bit 0 clear enables switching; reset leaves it enabled
// R18 - low setting above high setting fixes current at the higher value
// R19 - operating state field bits 7:6 reads normal or rest mode one to three
// R20 - writing 0x40, 0x80, 0xc0 forces rest mode one, two, three
// R21 - writing 0x00 releases forced rest mode back to normal
// R22 - reserved bits read as zero and writes to them do nothing
package sip_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_PREFLASH = 8'h34;
  localparam logic [7:0] ADDR_GAP      = 8'h35;
  localparam logic [7:0] ADDR_RESET    = 8'h3a;
  localparam logic [7:0] ADDR_DOWN     = 8'h3b;
  localparam logic [7:0] ADDR_INVREV   = 8'h3f;
  localparam logic [7:0] ADDR_ILLUM    = 8'h40;
  localparam logic [7:0] ADDR_MOTION   = 8'h41;
  localparam logic [7:0] ADDR_ADAPT    = 8'h43;
  localparam logic [7:0] ADDR_OPSTATE  = 8'h45;
  // ************************************************************
  // reset values and writable masks
  // ************************************************************
  localparam logic [7:0] RST_PREFLASH  = 8'ha0;
  localparam logic [7:0] RST_GAP       = 8'h00;
  localparam logic [7:0] RST_ILLUM     = 8'h00;
  localparam logic [7:0] RST_MOTION    = 8'h40;
  localparam logic [7:0] RST_ADAPT     = 8'h08;
  localparam logic [7:0] MASK_ILLUM    = 8'h0f;
  localparam logic [7:0] MASK_MOTION   = 8'hc0;
  localparam logic [7:0] MASK_ADAPT    = 8'h0f;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_FORCE_OFF = 3;
  localparam int BIT_FORCE_ON  = 2;
  localparam int FIX_LSB       = 0;
  localparam int BIT_POLARITY  = 7;
  localparam int BIT_EDGE      = 6;
  localparam int HIGH_LSB      = 2;
  localparam int BIT_LOW       = 1;
  localparam int BIT_ADAPT_OFF = 0;
  localparam int STATE_LSB     = 6;
  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0] CMD_FULL_A   = 8'h5a;
  localparam logic [7:0] CMD_FULL_B   = 8'h5b;
  localparam logic [7:0] CMD_PART_A   = 8'h96;
  localparam logic [7:0] CMD_PART_B   = 8'h97;
  localparam logic [7:0] CMD_DOWN     = 8'he7;
  localparam logic [7:0] MODE_NORMAL  = 8'h00;
  localparam logic [7:0] MODE_REST1   = 8'h40;
  localparam logic [7:0] MODE_REST2   = 8'h80;
  localparam logic [7:0] MODE_REST3   = 8'hc0;
  // ************************************************************
  // timing counts and currents
  // ************************************************************
  localparam logic [17:0] STEP_CLOCKS   = 18'h00020;   // 32 clocks per step
  localparam logic [17:0] PREFLASH_BASE = 18'h0001e;   // 30 clocks
  localparam logic [17:0] FRAME_BASE    = 18'h00d48;   // 3400 clocks
  localparam logic [5:0]  MA_15 = 6'h0f;
  localparam logic [5:0]  MA_20 = 6'h14;
  localparam logic [5:0]  MA_30 = 6'h1e;
  localparam logic [5:0]  MA_36 = 6'h24;
  // ************************************************************
  // power state
  // ************************************************************
  typedef enum logic [1:0] {
    PWR_RUN  = 2'b01,
    PWR_DOWN = 2'b10
  } sip_pwr_t;
endpackage

// ### verif/sip_host_model.sv
// Purpose: controller side of the register port
// Assumes: one-cycle strobes, read data one cycle after the read edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sip_host_model (
  // clock
  input  wire logic       clock,
  // register port
  output var  logic       reg_write = 1'b0,
  output var  logic       reg_read  = 1'b0,
  output var  logic [7:0] reg_addr  = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// ### verif/sip_illum_power_regs_tb_top.sv
// Purpose: register-port bench for the illumination and power group
// Assumes: host model drives one-cycle strobes
// Notes:   short shutter keeps the frame checks brief
`timescale 1ns/1ps
`default_nettype none
module sip_illum_power_regs_tb_top;
  logic        clock, reset, surface_bright, motion_event, motion_clear, reg_write;
  logic        reg_read, reg_rvalid, illum_on, motion_out, frame_start, forced_rest;
  logic        full_reset_pulse, partial_reset_pulse, powered_down;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, revision_id;
  logic [15:0] shutter_time;
  logic [1:0]  rest_state_auto, operating_state_field;
  logic [5:0]  illum_current_ma;
  int          err_count = 0, n_compared = 0, cnt = 0, period = 0, run = 0, on_len = 0;
  int          n_full = 0, n_part = 0;
  localparam logic [7:0] RA [8] = '{8'h34, 8'h35, 8'h40, 8'h41, 8'h43, 8'h45, 8'h3f, 8'h3a};
  localparam logic [7:0] RV [8] = '{8'ha0, 8'h00, 8'h00, 8'h40, 8'h08, 8'h40, 8'hc3, 8'h00};
  localparam logic [5:0] FX [4] = '{6'h14, 6'h0f, 6'h24, 6'h1e};
  sip_host_model HOST (.*);
  sip_illum_power_regs DUT (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cnt <= frame_start ? 1 : cnt + 1;
    run <= illum_on ? run + 1 : 0;
    if (frame_start) period <= cnt;
    if (!illum_on && run != 0) on_len <= run;
    if (full_reset_pulse) n_full <= n_full + 1;
    if (partial_reset_pulse) n_part <= n_part + 1;
  end
  task automatic wi(input logic [7:0] a, input logic [7:0] d);
    HOST.wr(a, d);
    repeat (3) @(posedge clock);
  endtask
  task automatic cmp(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    HOST.rd(a, d, v);
    cmp("rvalid", 18'h1, {17'h0, v});
    cmp("rdata", {10'h0, e}, {10'h0, d});
  endtask
  task automatic summarize;
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog well beyond the few frames the run needs
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    summarize();
  end
  initial begin
    {reset, surface_bright, motion_event, motion_clear} = 4'h8;
    {revision_id, shutter_time, rest_state_auto} = {8'h3c, 16'h0064, 2'h1};
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    foreach (RA[i]) rdchk(RA[i], RV[i]);
    HOST.wr(8'h40, 8'hff);
    rdchk(8'h40, 8'h0f);
    HOST.wr(8'h43, 8'h09);
    for (int k = 0; k < 4; k++) begin
      wi(8'h40, 8'(k));
      cmp("fixed mA", {12'h0, FX[k]}, {12'h0, illum_current_ma});
    end
    surface_bright <= 1'b1;
    wi(8'h43, 8'h0c);
    cmp("bright mA", 18'h0000f, {12'h0, illum_current_ma});
    surface_bright <= 1'b0;
    wi(8'h43, 8'h0c);
    cmp("dark mA", 18'h00024, {12'h0, illum_current_ma});
    wi(8'h43, 8'h02);
    cmp("low over high mA", 18'h00014, {12'h0, illum_current_ma});
    wi(8'h40, 8'h04);
    cmp("forced on", 18'h1, {17'h0, illum_on});
    wi(8'h40, 8'h0c);
    cmp("forced off", 18'h0, {17'h0, illum_on});
    HOST.wr(8'h40, 8'h00);
    HOST.wr(8'h35, 8'h02);
    HOST.wr(8'h34, 8'h01);
    // settings land at a frame start, so skip one frame first
    repeat (3) @(posedge frame_start);
    repeat (2) @(posedge clock);
    cmp("frame period", 18'h00dec, 18'(period));
    cmp("preflash", 18'h0003e, 18'(on_len));
    for (int m = 1; m < 4; m++) begin
      wi(8'h45, {2'(m), 6'h00});
      rdchk(8'h45, {2'(m), 6'h00});
      cmp("state", 18'(m), {16'h0, operating_state_field});
      cmp("forced", 18'h1, {17'h0, forced_rest});
    end
    wi(8'h45, 8'h00);
    rdchk(8'h45, 8'h40);
    cmp("unforced", 18'h0, {17'h0, forced_rest});
    motion_event <= 1'b1;
    @(posedge clock) motion_event <= 1'b0;
    repeat (2) @(posedge clock);
    cmp("edge pulse", 18'h0, {17'h0, motion_out});
    @(posedge clock);
    cmp("edge end", 18'h1, {17'h0, motion_out});
    wi(8'h41, 8'h80);
    cmp("level held", 18'h1, {17'h0, motion_out});
    motion_clear <= 1'b1;
    @(posedge clock) motion_clear <= 1'b0;
    repeat (3) @(posedge clock);
    cmp("level clear", 18'h0, {17'h0, motion_out});
    {motion_event, motion_clear} <= 2'b11;
    @(posedge clock) {motion_event, motion_clear} <= 2'b00;
    repeat (3) @(posedge clock);
    cmp("set beats clear", 18'h1, {17'h0, motion_out});
    wi(8'h3b, 8'he7);
    cmp("down", 18'h1, {17'h0, powered_down});
    HOST.wr(8'h3a, 8'h97);
    wi(8'h3a, 8'h5a);
    cmp("awake", 18'h0, {17'h0, powered_down});
    HOST.wr(8'h3a, 8'h96);
    HOST.wr(8'h3a, 8'h97);
    wi(8'h3a, 8'h5b);
    cmp("full resets", 18'h2, 18'(n_full));
    cmp("partial resets", 18'h2, 18'(n_part));
    rdchk(8'h35, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
